// ### src/dma_channel_address_size.v
// per-channel base, offset and size registers with byte transfer path to data memory
`timescale 1ns/10ps
`include "dma_chan_regs.vh"

module dma_channel_address_size (
  input wire i_mclk,
  input wire i_nrst,
  input wire [3:0] i_sfr_page,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  output wire [7:0] o_sfr_rdata,
  input wire i_xfer_start,
  input wire [2:0] i_xfer_chan,
  output wire o_xfer_busy,
  output wire o_xfer_done,
  input wire i_per_valid,
  input wire [7:0] i_per_data,
  output wire o_per_ready,
  output wire o_mem_wr,
  output wire [11:0] o_mem_addr,
  output wire [7:0] o_mem_wdata,
  input wire i_mem_ready
);
  reg [2:0] sel_ff;
  reg [`BASE_W-1:0] base_ff [0:`NUM_CHAN-1];
  reg [`OFFSET_W-1:0] off_ff [0:`NUM_CHAN-1];
  reg [`SIZE_W-1:0] size_ff [0:`NUM_CHAN-1];
  reg [7:0] rdata_ff;
  reg [7:0] nxt_rdata;
  reg busy_ff;
  reg done_ff;
  reg [2:0] act_ff;
  reg [`SIZE_W-1:0] in_cnt_ff;
  reg [`SIZE_W-1:0] out_cnt_ff;
  reg mem_wr_ff;
  reg [11:0] mem_addr_ff;
  reg [7:0] mem_wdata_ff;
  wire [6:0] sel_oh;
  wire sel_valid;
  wire page_hit;
  wire wr_hit;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_out_ready;
  wire src_open;
  wire pop;
  wire finish;
  integer c;
  integer c_off;
  wire [`SIZE_W-1:0] act_size;
  wire start_valid;
  wire start_ok;
  wire take;
  wire mem_free;
  wire sel_hit;
  wire rd_indirect;
  wire [11:0] cur_addr;

  // base plus offset, wrapping in the data memory space
  function [11:0] mem_addr_of;
    input [`BASE_W-1:0] base;
    input [`OFFSET_W-1:0] off;
    reg [12:0] sum;
    begin
      sum = {1'b0, base} + {3'h0, off};
      mem_addr_of = sum[11:0];
    end
  endfunction

  // true while a byte count is short of the size
  function below_size;
    input [`SIZE_W-1:0] cnt;
    input [`SIZE_W-1:0] size;
    begin
      below_size = (cnt != size);
    end
  endfunction

  // ten bit step by one, wrapping
  function [9:0] step10;
    input [9:0] v;
    begin
      step10 = v + 10'h001;
    end
  endfunction

  chan_sel_decode u_sel_decode (
    .i_sel(sel_ff),
    .o_onehot(sel_oh),
    .o_valid(sel_valid)
  );

  // reserved code refused as transfer channel
  chan_sel_decode u_start_decode (
    .i_sel(i_xfer_chan),
    .o_onehot(),
    .o_valid(start_valid)
  );

  assign page_hit = (i_sfr_page == `SFR_PAGE_DMA);
  assign wr_hit = i_sfr_wr && page_hit;
  assign sel_hit = page_hit && (i_sfr_addr == `ADDR_CHANNEL_SELECT_REG);
  assign rd_indirect = page_hit && sel_valid;

  // size of the running channel
  assign act_size = size_ff[act_ff];

  // limit bytes accepted to the count
  assign src_open = busy_ff && below_size(in_cnt_ff, act_size);
  assign o_per_ready = src_open && fifo_in_ready;
  assign take = i_per_valid && o_per_ready;

  byte_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_in_valid(i_per_valid && src_open),
    .i_in_data(i_per_data),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_out_ready)
  );

  assign mem_free = !mem_wr_ff || i_mem_ready;
  assign fifo_out_ready = busy_ff && below_size(out_cnt_ff, act_size) && mem_free;
  assign pop = fifo_out_valid && fifo_out_ready;
  // done once last byte taken by memory
  assign finish = busy_ff && !below_size(out_cnt_ff, act_size) && !mem_wr_ff;
  // address of the byte leaving the fifo
  assign cur_addr = mem_addr_of(base_ff[act_ff], off_ff[act_ff]);
  // start only when idle on a valid channel
  assign start_ok = !busy_ff && i_xfer_start && start_valid;

  // channel select register
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_ff <= `RST_SEL;
    end else if (i_sfr_wr && sel_hit) begin
      sel_ff <= i_sfr_wdata[`SEL_MSB:0];
    end
  end

  // per-channel registers
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (c = 0; c < `NUM_CHAN; c = c + 1) begin
        base_ff[c] <= `RST_BASE;
        size_ff[c] <= `RST_SIZE;
      end
    end else begin
      for (c = 0; c < `NUM_CHAN; c = c + 1) begin
        if (wr_hit && sel_oh[c]) begin
          case (i_sfr_addr)
            `ADDR_CHAN_BASE_ADDR_LOW: begin
              base_ff[c][7:0] <= i_sfr_wdata;
            end
            `ADDR_CHAN_BASE_ADDR_HIGH: begin
              base_ff[c][11:8] <= i_sfr_wdata[`BASE_UPPER_MSB:0];
            end
            `ADDR_CHAN_XFER_SIZE_LOW: begin
              size_ff[c][7:0] <= i_sfr_wdata;
            end
            `ADDR_CHAN_XFER_SIZE_HIGH: begin
              size_ff[c][9:8] <= i_sfr_wdata[`SIZE_UPPER_MSB:0];
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // offset step per byte, software write wins
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (c_off = 0; c_off < `NUM_CHAN; c_off = c_off + 1) begin
        off_ff[c_off] <= `RST_OFFSET;
      end
    end else begin
      for (c_off = 0; c_off < `NUM_CHAN; c_off = c_off + 1) begin
        if (pop && act_ff == c_off[2:0]) begin
          off_ff[c_off] <= step10(off_ff[c_off]);
        end
        if (wr_hit && sel_oh[c_off] && i_sfr_addr == `ADDR_CHAN_ADDR_OFFSET_LOW) begin
          off_ff[c_off][7:0] <= i_sfr_wdata;
        end
        if (wr_hit && sel_oh[c_off] && i_sfr_addr == `ADDR_CHAN_ADDR_OFFSET_HIGH) begin
          off_ff[c_off][9:8] <= i_sfr_wdata[`OFFSET_UPPER_MSB:0];
        end
      end
    end
  end

  // read mux, reserved bits zero
  always @* begin
    nxt_rdata = `RST_BYTE;
    if (sel_hit) begin
      nxt_rdata = {5'h00, sel_ff};
    end else if (rd_indirect) begin
      case (i_sfr_addr)
        `ADDR_CHAN_BASE_ADDR_LOW: begin
          nxt_rdata = base_ff[sel_ff][7:0];
        end
        `ADDR_CHAN_BASE_ADDR_HIGH: begin
          nxt_rdata = {4'h0, base_ff[sel_ff][11:8]};
        end
        `ADDR_CHAN_ADDR_OFFSET_LOW: begin
          nxt_rdata = off_ff[sel_ff][7:0];
        end
        `ADDR_CHAN_ADDR_OFFSET_HIGH: begin
          nxt_rdata = {6'h00, off_ff[sel_ff][9:8]};
        end
        `ADDR_CHAN_XFER_SIZE_LOW: begin
          nxt_rdata = size_ff[sel_ff][7:0];
        end
        `ADDR_CHAN_XFER_SIZE_HIGH: begin
          nxt_rdata = {6'h00, size_ff[sel_ff][9:8]};
        end
        default: begin
          nxt_rdata = `RST_BYTE;
        end
      endcase
    end
  end

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= `RST_BYTE;
    end else if (i_sfr_rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // transfer control
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      act_ff <= 3'h0;
      in_cnt_ff <= `RST_SIZE;
      out_cnt_ff <= `RST_SIZE;
    end else begin
      done_ff <= finish;
      if (finish) begin
        busy_ff <= 1'b0;
      end else if (start_ok) begin
        busy_ff <= 1'b1;
        act_ff <= i_xfer_chan;
        in_cnt_ff <= `RST_SIZE;
        out_cnt_ff <= `RST_SIZE;
      end else begin
        if (take) begin
          in_cnt_ff <= step10(in_cnt_ff);
        end
        if (pop) begin
          out_cnt_ff <= step10(out_cnt_ff);
        end
      end
    end
  end

  // memory write stage
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mem_wr_ff <= 1'b0;
      mem_addr_ff <= 12'h000;
      mem_wdata_ff <= `RST_BYTE;
    end else if (pop) begin
      mem_wr_ff <= 1'b1;
      mem_addr_ff <= cur_addr;
      mem_wdata_ff <= fifo_out_data;
    end else if (i_mem_ready) begin
      mem_wr_ff <= 1'b0;
    end
  end

  assign o_sfr_rdata = rdata_ff;
  assign o_xfer_busy = busy_ff;
  assign o_xfer_done = done_ff;
  assign o_mem_wr = mem_wr_ff;
  assign o_mem_addr = mem_addr_ff;
  assign o_mem_wdata = mem_wdata_ff;
endmodule

// ### src/dma_chan_regs.vh
// offsets, field positions, reset values and sizes of the dma channel address block
`ifndef DMA_CHAN_REGS_VH
`define DMA_CHAN_REGS_VH

`define SFR_PAGE_DMA 4'hF
`define ADDR_CHANNEL_SELECT_REG 8'h94
`define ADDR_CHAN_BASE_ADDR_LOW 8'hC9
`define ADDR_CHAN_BASE_ADDR_HIGH 8'hCA
`define ADDR_CHAN_ADDR_OFFSET_LOW 8'hCB
`define ADDR_CHAN_ADDR_OFFSET_HIGH 8'hCC
`define ADDR_CHAN_XFER_SIZE_LOW 8'hCD
`define ADDR_CHAN_XFER_SIZE_HIGH 8'hCE

`define SEL_MSB 2
`define BASE_UPPER_MSB 3
`define OFFSET_UPPER_MSB 1
`define SIZE_UPPER_MSB 1
`define BASE_W 12
`define OFFSET_W 10
`define SIZE_W 10
`define NUM_CHAN 7
`define SEL_RESERVED 3'h7

`define RST_BYTE 8'h00
`define RST_SEL 3'h0
`define RST_BASE 12'h000
`define RST_OFFSET 10'h000
`define RST_SIZE 10'h000

`define FIFO_WIDTH 8
`define FIFO_DEPTH 8
`define FIFO_AW 3

`endif

// ### src/chan_sel_decode.v
// channel select decoder: one-hot channel and validity
`timescale 1ns/10ps
`include "dma_chan_regs.vh"
module chan_sel_decode (
  input wire [2:0] i_sel,
  output reg [6:0] o_onehot,
  output wire o_valid
);
  assign o_valid = (i_sel != `SEL_RESERVED);

  always @* begin
    o_onehot = 7'h00;
    if (i_sel != `SEL_RESERVED) begin
      o_onehot[i_sel] = 1'b1;
    end
  end
endmodule

// ### src/byte_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_mclk,
  input wire i_nrst,
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wptr_ff;
  reg [AW-1:0] rptr_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_ff != DEPTH[AW:0]);
  assign o_out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign o_out_data = mem_ff[rptr_ff];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always @(posedge i_mclk) begin
    if (push) begin
      mem_ff[wptr_ff] <= i_in_data;
    end
  end

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wptr_ff <= {AW{1'b0}};
      rptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= (rptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ### verification/dma_chan_sva.sv
// assertions for the dma channel address block
`timescale 1ns/10ps
module dma_chan_sva (
  input wire i_mclk,
  input wire i_nrst,
  input wire [3:0] i_sfr_page,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_rd,
  input wire [7:0] o_sfr_rdata,
  input wire i_xfer_start,
  input wire [2:0] i_xfer_chan,
  input wire o_xfer_busy,
  input wire o_xfer_done,
  input wire o_per_ready,
  input wire o_mem_wr,
  input wire [11:0] o_mem_addr,
  input wire [7:0] o_mem_wdata,
  input wire i_mem_ready
);
  reg [11:0] last_ff;
  reg seen_ff;
  reg new_ff;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      last_ff <= 12'h000;
      seen_ff <= 1'b0;
      new_ff <= 1'b1;
    end else begin
      new_ff <= !o_mem_wr || i_mem_ready;
      seen_ff <= o_xfer_busy && (seen_ff || o_mem_wr && i_mem_ready);
      if (o_mem_wr && i_mem_ready) last_ff <= o_mem_addr;
    end
  end
  sequence rd_hi; i_sfr_rd && i_sfr_page == 4'hF; endsequence
  sequence go; i_xfer_start && !o_xfer_busy; endsequence
  AST_BASE_RSV: assert property (rd_hi ##0 i_sfr_addr == 8'hCA |=> o_sfr_rdata[7:4] == 4'h0)
    else $error("base high reserved bits set");
  sequence ofs_sz_hi; i_sfr_addr == 8'hCC || i_sfr_addr == 8'hCE; endsequence
  AST_OFS_SZ_RSV: assert property (rd_hi ##0 ofs_sz_hi |=> o_sfr_rdata[7:2] == 6'h00)
    else $error("high reserved bits set");
  AST_RD_HOLD: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data changed");
  AST_START: assert property (go ##0 i_xfer_chan != 3'h7 |=> o_xfer_busy)
    else $error("start missed");
  AST_CHAN_RSV: assert property (go ##0 i_xfer_chan == 3'h7 |=> !o_xfer_busy)
    else $error("reserved channel ran");
  sequence mem_held; o_mem_wr && $stable(o_mem_addr) && $stable(o_mem_wdata); endsequence
  AST_MEM_HOLD: assert property (o_mem_wr && !i_mem_ready |=> mem_held)
    else $error("memory request dropped");
  AST_ADDR_STEP: assert property (o_mem_wr && new_ff && seen_ff |-> o_mem_addr == last_ff + 12'h001)
    else $error("address step wrong");
  AST_DONE_END: assert property (o_xfer_done |-> !o_xfer_busy && $past(o_xfer_busy))
    else $error("done without end");
  AST_DONE_PULSE: assert property (o_xfer_done |=> !o_xfer_done)
    else $error("done too long");
  AST_IDLE: assert property (!o_xfer_busy |-> !o_per_ready && !o_mem_wr)
    else $error("idle activity");
endmodule
bind dma_channel_address_size dma_chan_sva i_sva (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sfr_page(i_sfr_page),
  .i_sfr_addr(i_sfr_addr), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata), .i_xfer_start(i_xfer_start),
  .i_xfer_chan(i_xfer_chan), .o_xfer_busy(o_xfer_busy), .o_xfer_done(o_xfer_done), .o_per_ready(o_per_ready),
  .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ready(i_mem_ready));

// ### verification/mem_model.sv
// data memory model, prompt or slow acceptance
`timescale 1ns/10ps
module mem_model (
  input wire i_mclk,
  input wire i_wr,
  input wire [11:0] i_addr,
  input wire [7:0] i_data,
  input wire i_slow,
  output logic o_ready
);
  logic [7:0] mem [0:4095];
  logic tog;
  initial begin
    o_ready = 1'b0;
    tog = 1'b0;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
  end
  always @(posedge i_mclk) begin
    if (i_wr && o_ready) mem[i_addr] <= i_data;
    tog <= ~tog;
    o_ready <= !i_slow || tog;
  end
endmodule

// ### verification/tb.sv
// self-checking bench for the dma channel address block
`timescale 1ns/10ps
module tb;
  logic i_mclk, i_nrst, i_sfr_wr, i_sfr_rd, i_xfer_start, i_per_valid, slow, took, seen;
  logic [3:0] i_sfr_page;
  logic [7:0] i_sfr_addr, i_sfr_wdata, i_per_data;
  logic [2:0] i_xfer_chan;
  logic [11:0] a;
  wire [7:0] o_sfr_rdata, o_mem_wdata;
  wire [11:0] o_mem_addr;
  wire o_xfer_busy, o_xfer_done, o_per_ready, o_mem_wr, i_mem_ready;
  int n_errors, check_count, cyc, k;
  dma_channel_address_size i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_sfr_page(i_sfr_page),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_xfer_start(i_xfer_start), .i_xfer_chan(i_xfer_chan),
    .o_xfer_busy(o_xfer_busy), .o_xfer_done(o_xfer_done), .i_per_valid(i_per_valid),
    .i_per_data(i_per_data), .o_per_ready(o_per_ready), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .i_mem_ready(i_mem_ready));
  mem_model i_mem (.i_mclk(i_mclk), .i_wr(o_mem_wr), .i_addr(o_mem_addr), .i_data(o_mem_wdata),
    .i_slow(slow), .o_ready(i_mem_ready));
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  task stop_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  task chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(negedge i_mclk);
    i_sfr_wr = 1'b1;
    i_sfr_addr = ad;
    i_sfr_wdata = d;
    @(negedge i_mclk);
    i_sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [7:0] e);
    @(negedge i_mclk);
    i_sfr_rd = 1'b1;
    i_sfr_addr = ad;
    @(negedge i_mclk);
    i_sfr_rd = 1'b0;
    chk(o_sfr_rdata, e);
  endtask
  task cfg(input logic [2:0] c, input logic [11:0] b, input logic [9:0] o, input logic [9:0] s);
    wr(8'h94, {5'h00, c});
    wr(8'hC9, b[7:0]);
    wr(8'hCA, {4'h0, b[11:8]});
    wr(8'hCB, o[7:0]);
    wr(8'hCC, {6'h00, o[9:8]});
    wr(8'hCD, s[7:0]);
    wr(8'hCE, {6'h00, s[9:8]});
  endtask
  // runs one transfer, offering bytes until done
  task xfer(input logic [2:0] c, input int offer, input int n);
    seen = 1'b0;
    took = 1'b0;
    k = 0;
    @(negedge i_mclk);
    i_xfer_start = 1'b1;
    i_xfer_chan = c;
    @(negedge i_mclk);
    i_xfer_start = 1'b0;
    for (int t = 0; t < 300 && !seen; t++) begin
      if (t > 0) @(negedge i_mclk);
      if (took) k++;
      seen = o_xfer_done;
      i_per_valid = k < offer;
      i_per_data = i_per_valid ? 8'hA0 + k[7:0] : ~i_per_data;
      #1 took = i_per_valid && o_per_ready;
    end
    i_per_valid = 1'b0;
    chk(seen, 1);
    chk(k, n);
  endtask
  task mem_chk(input logic [11:0] b, input int n);
    for (int j = 0; j < n; j++) begin
      a = b + j[11:0];
      chk(i_mem.mem[a], 8'hA0 + j[7:0]);
    end
  endtask
  initial begin
    i_nrst = 0; i_sfr_wr = 0; i_sfr_rd = 0; i_sfr_page = 4'hF; i_sfr_addr = 0; i_sfr_wdata = 0;
    i_xfer_start = 0; i_xfer_chan = 0; i_per_valid = 0; i_per_data = 0; slow = 1;
    repeat (2) @(negedge i_mclk);
    i_nrst = 1;
    for (int r = 8'hC9; r <= 8'hCE; r++) rd(r[7:0], 8'h00);
    for (int c = 0; c < 7; c++) begin
      cfg(c[2:0], {4'hF, 8'h10 + c[7:0]}, {2'h3, 8'h20 + c[7:0]}, {2'h3, 8'h30 + c[7:0]});
    end
    for (int c = 0; c < 7; c++) begin
      wr(8'h94, c[7:0]);
      rd(8'hC9, 8'h10 + c[7:0]);
      rd(8'hCA, 8'h0F);
      rd(8'hCB, 8'h20 + c[7:0]);
      rd(8'hCC, 8'h03);
      rd(8'hCD, 8'h30 + c[7:0]);
      rd(8'hCE, 8'h03);
    end
    wr(8'hCA, 8'h05);
    rd(8'hCA, 8'h05);
    wr(8'hCE, 8'h01);
    rd(8'hCE, 8'h01);
    wr(8'h94, 8'h07);
    wr(8'hC9, 8'h55);
    rd(8'hC9, 8'h00);
    i_sfr_page = 4'h0;
    rd(8'h94, 8'h00);
    wr(8'h94, 8'h03);
    i_sfr_page = 4'hF;
    rd(8'h94, 8'h07);
    wr(8'h94, 8'h06);
    rd(8'hC9, 8'h16);
    cfg(3'h2, 12'hFFE, 10'h000, 10'h004);
    xfer(3'h2, 6, 4);
    mem_chk(12'hFFE, 4);
    rd(8'hCB, 8'h04);
    slow = 0;
    cfg(3'h5, 12'h123, 10'h005, 10'h003);
    xfer(3'h5, 6, 3);
    mem_chk(12'h128, 3);
    chk(i_mem.mem[12'h12B], 8'h00);
    rd(8'hCB, 8'h08);
    cfg(3'h4, 12'h200, 10'h000, 10'h000);
    xfer(3'h4, 2, 0);
    @(negedge i_mclk);
    i_xfer_start = 1'b1;
    i_xfer_chan = 3'h7;
    @(negedge i_mclk);
    i_xfer_start = 1'b0;
    chk(o_xfer_busy, 0);
    @(negedge i_mclk);
    i_nrst = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_nrst = 1'b1;
    rd(8'h94, 8'h00);
    rd(8'hCB, 8'h00);
    stop_test();
  end
endmodule
